// ### upts_top.sv
// Purpose: USB power control and last-transfer status with APB access
// Assumes: Engine events arrive on clock_i; wake level is asynchronous
// Notes:   Registers occupy bits 15:0 of each 32-bit word
//
// Operation
// [R1] Hardware sets activity pending only under guard
// [R2] Software sets guard before suspend or power-down
// [R3] Suspend gates clock, idles transceiver; hardware clears
// [R4] Operation enable switches module; resets to zero
// [R5] Clear enables before clearing operation enable
// [R6] Unimplemented bits read zero, ignore writes
// [R7] Last endpoint number loaded after each transfer; code loads only while operation enable is set
// [R8] Direction reads one for transmit, zero receive
// [R9] Bank reads one for odd, zero even
// [R10] Bank meaningful only for ping-pong endpoints
// [R11] Status fields read-only, hardware-set, reset zero
// [R12] Endpoint, direction, bank update together
`timescale 1ns/10ps
module upts_top
  import upts_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Engine side
  input  wire logic        xfer_done_i,
  input  wire upts_xfer_t  xfer_i,
  input  wire logic        activity_i,
  input  wire logic        bus_wake_i,
  // Power outputs
  output logic             module_on_o,
  output logic             usb_clk_gate_o,
  output logic             xcvr_lowpwr_o,
  output logic             host_mode_enable_o,
  output logic             module_enable_o,
  output logic             otg_features_enable_o,
  // Interrupt
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  function automatic logic [31:0] half(input logic [15:0] v);
    half = {UPTS_ZERO_HALF, v};                            // [R6]
  endfunction : half

  upts_apb_req_t req;
  assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                 paddr: paddr_i, pwdata: pwdata_i};

  // Single-wait answer: access phase ends on its second cycle, two cycles after setup
  logic access;
  logic wr_en;
  logic valid_addr;
  assign access = req.psel & req.penable & pready_o;
  assign wr_en  = access & req.pwrite;
  assign valid_addr = hit(req.paddr, UPTS_OFS_PWR)
                    | hit(req.paddr, UPTS_OFS_STAT)
                    | hit(req.paddr, UPTS_OFS_IRQ_ST)
                    | hit(req.paddr, UPTS_OFS_IRQ_MSK)
                    | hit(req.paddr, UPTS_OFS_ENG);

  // ----------------------------------------------------------------
  // Wake input synchroniser
  // ----------------------------------------------------------------
  logic wake_s;

  upts_sync u_wake (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     (bus_wake_i),
    .q_o     (wake_s)
  );

  // ----------------------------------------------------------------
  // Power control register
  // ----------------------------------------------------------------
  logic enable_q;
  logic suspend_q;
  logic guard_q;
  logic pend_q;
  logic pend_set;
  logic wake_rise;
  logic wake_d1_q;
  upts_pw_state_t pw_state;

  assign wake_rise = wake_s & ~wake_d1_q;
  assign pend_set  = guard_q & activity_i;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      wake_d1_q <= 1'b0;
    else
      wake_d1_q <= wake_s;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      enable_q <= 1'b0;                                    // [R4]
      guard_q  <= 1'b0;
    end
    else if (wr_en && hit(req.paddr, UPTS_OFS_PWR))
    begin
      enable_q <= req.pwdata[UPTS_PWR_ENABLE_BIT];         // [R4]
      guard_q  <= req.pwdata[UPTS_PWR_GUARD_BIT];          // [R2]
    end
  end

  // Hardware clear on bus wake beats a software set in the same cycle
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      suspend_q <= 1'b0;
    else if (wake_rise || !enable_q)
      suspend_q <= 1'b0;                                   // [R3]
    else if (wr_en && hit(req.paddr, UPTS_OFS_PWR))
      suspend_q <= req.pwdata[UPTS_PWR_SUSPEND_BIT];       // [R3]
  end

  // Pending only while guarded; dropping the guard releases it
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      pend_q <= 1'b0;
    else if (!guard_q)
      pend_q <= 1'b0;                                      // [R1]
    else if (pend_set)
      pend_q <= 1'b1;                                      // [R1]
    else if (!activity_i)
      pend_q <= 1'b0;
  end

  always_comb
  begin
    if (!enable_q)
      pw_state = UPTS_PW_OFF;
    else if (suspend_q)
      pw_state = UPTS_PW_SUSPEND;
    else
      pw_state = UPTS_PW_RUN;
  end

  // ----------------------------------------------------------------
  // Engine enable register
  // ----------------------------------------------------------------
  logic host_q;
  logic mod_q;
  logic otg_q;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      host_q <= 1'b0;
      mod_q  <= 1'b0;
      otg_q  <= 1'b0;
    end
    else if (wr_en && hit(req.paddr, UPTS_OFS_ENG))
    begin
      host_q <= req.pwdata[UPTS_ENG_HOST_BIT];
      mod_q  <= req.pwdata[UPTS_ENG_MOD_BIT];
      otg_q  <= req.pwdata[UPTS_ENG_OTG_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Last transfer status
  // ----------------------------------------------------------------
  upts_xfer_t last_xfer;
  logic       done_ok;

  // Completions are meaningless with the module switched off
  assign done_ok = xfer_done_i & enable_q;

  upts_xfer_status u_stat (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .done_i  (done_ok),                                    // [R12]
    .xfer_i  (xfer_i),
    .last_o  (last_xfer)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [UPTS_IRQ_W-1:0] irq_st_q;
  logic [UPTS_IRQ_W-1:0] irq_msk_q;
  logic [UPTS_IRQ_W-1:0] irq_ev;
  logic [UPTS_IRQ_W-1:0] irq_clr;
  logic                  pend_d1_q;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      pend_d1_q <= 1'b0;
    else
      pend_d1_q <= pend_q;
  end

  always_comb
  begin
    irq_ev = '0;
    irq_ev[UPTS_IRQ_DONE_BIT] = done_ok;
    irq_ev[UPTS_IRQ_WAKE_BIT] = wake_rise & suspend_q;
    irq_ev[UPTS_IRQ_PEND_BIT] = pend_d1_q & ~pend_q;
  end

  assign irq_clr = (wr_en && hit(req.paddr, UPTS_OFS_IRQ_ST))
                 ? req.pwdata[UPTS_IRQ_W-1:0] : '0;

  // A new event in the clearing cycle keeps its bit
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      irq_st_q <= '0;
    else
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      irq_msk_q <= '0;
    else if (wr_en && hit(req.paddr, UPTS_OFS_IRQ_MSK))
      irq_msk_q <= req.pwdata[UPTS_IRQ_W-1:0];
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(((irq_st_q & ~irq_clr) | irq_ev) & irq_msk_q);
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [15:0] pwr_word;
  logic [15:0] stat_word;
  logic [15:0] eng_word;
  logic [31:0] rd_word;

  always_comb
  begin
    pwr_word = UPTS_ZERO_HALF;                             // [R6]
    pwr_word[UPTS_PWR_ENABLE_BIT]  = enable_q;
    pwr_word[UPTS_PWR_SUSPEND_BIT] = suspend_q;
    pwr_word[UPTS_PWR_GUARD_BIT]   = guard_q;
    // Guard masks the flag in the cycle after software drops it
    pwr_word[UPTS_PWR_PEND_BIT]    = pend_q & guard_q;     // [R1]
    stat_word = UPTS_ZERO_HALF;                            // [R6]
    stat_word[UPTS_ST_EP_LSB +: 4]  = last_xfer.endpoint;  // [R7]
    stat_word[UPTS_ST_DIR_BIT]      = last_xfer.transmit;  // [R8]
    // Valid only for ping-pong endpoints; software filters it
    stat_word[UPTS_ST_BANK_BIT]     = last_xfer.odd_bank;  // [R9] [R10]
    eng_word = UPTS_ZERO_HALF;
    eng_word[UPTS_ENG_HOST_BIT] = host_q;
    eng_word[UPTS_ENG_MOD_BIT]  = mod_q;
    eng_word[UPTS_ENG_OTG_BIT]  = otg_q;
    if (hit(req.paddr, UPTS_OFS_PWR))
      rd_word = half(pwr_word);
    else if (hit(req.paddr, UPTS_OFS_STAT))
      rd_word = half(stat_word);                           // [R11]
    else if (hit(req.paddr, UPTS_OFS_IRQ_ST))
      rd_word = {{(32-UPTS_IRQ_W){1'b0}}, irq_st_q};
    else if (hit(req.paddr, UPTS_OFS_IRQ_MSK))
      rd_word = {{(32-UPTS_IRQ_W){1'b0}}, irq_msk_q};
    else if (hit(req.paddr, UPTS_OFS_ENG))
      rd_word = half(eng_word);
    else
      rd_word = UPTS_ZERO_WORD;
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= UPTS_ZERO_WORD;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= req.psel & req.penable & ~pready_o;
      pslverr_o <= req.psel & req.penable & ~pready_o & ~valid_addr;
      if (req.psel && req.penable && !pready_o && !req.pwrite)
        prdata_o <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Power outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      module_on_o           <= 1'b0;
      usb_clk_gate_o        <= 1'b0;
      xcvr_lowpwr_o         <= 1'b0;
      host_mode_enable_o    <= 1'b0;
      module_enable_o       <= 1'b0;
      otg_features_enable_o <= 1'b0;
    end
    else
    begin
      case (pw_state)
        UPTS_PW_RUN:
        begin
          module_on_o    <= 1'b1;                          // [R4]
          usb_clk_gate_o <= 1'b0;
          xcvr_lowpwr_o  <= 1'b0;
        end
        UPTS_PW_SUSPEND:
        begin
          module_on_o    <= 1'b1;                          // [R4]
          usb_clk_gate_o <= 1'b1;                          // [R3]
          xcvr_lowpwr_o  <= 1'b1;                          // [R3]
        end
        default:
        begin
          // Off, and any illegal code, powers everything down
          module_on_o    <= 1'b0;                          // [R4]
          usb_clk_gate_o <= 1'b0;
          xcvr_lowpwr_o  <= 1'b0;
        end
      endcase
      // Engine controls follow only a powered module [R5]
      host_mode_enable_o    <= host_q & enable_q;
      module_enable_o       <= mod_q & enable_q;
      otg_features_enable_o <= otg_q & enable_q;
    end
  end

endmodule : upts_top

// ### upts_pkg.sv
// Purpose: Shared constants and types for USB power and transfer status
// Assumes: APB slave, 32-bit data, registers in low 16 bits
// Notes:   Offsets are byte addresses of aligned words
package upts_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] UPTS_OFS_PWR     = 8'h00;
  localparam logic [7:0] UPTS_OFS_STAT    = 8'h04;
  localparam logic [7:0] UPTS_OFS_IRQ_ST  = 8'h08;
  localparam logic [7:0] UPTS_OFS_IRQ_MSK = 8'h0c;
  localparam logic [7:0] UPTS_OFS_ENG     = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int UPTS_PWR_ENABLE_BIT  = 0;
  localparam int UPTS_PWR_SUSPEND_BIT = 1;
  localparam int UPTS_PWR_GUARD_BIT   = 4;
  localparam int UPTS_PWR_PEND_BIT    = 7;
  localparam int UPTS_ST_BANK_BIT     = 2;
  localparam int UPTS_ST_DIR_BIT      = 3;
  localparam int UPTS_ST_EP_LSB       = 4;
  localparam int UPTS_ENG_HOST_BIT    = 0;
  localparam int UPTS_ENG_MOD_BIT     = 1;
  localparam int UPTS_ENG_OTG_BIT     = 2;

  // Interrupt events
  localparam int UPTS_IRQ_DONE_BIT    = 0;
  localparam int UPTS_IRQ_WAKE_BIT    = 1;
  localparam int UPTS_IRQ_PEND_BIT    = 2;
  localparam int UPTS_IRQ_W           = 3;

  localparam logic [31:0] UPTS_ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] UPTS_ZERO_HALF = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] endpoint;
    logic       transmit;
    logic       odd_bank;
  } upts_xfer_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } upts_apb_req_t;

  typedef enum logic [1:0] {
    UPTS_PW_OFF,
    UPTS_PW_RUN,
    UPTS_PW_SUSPEND
  } upts_pw_state_t;

endpackage : upts_pkg

// ### upts_sync.sv
// Purpose: Two flip-flop synchroniser for one level
// Assumes: Input is asynchronous to clock_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module upts_sync
  import upts_pkg::*;
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // Level
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_q;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : upts_sync

// ### upts_xfer_status.sv
// Purpose: Holds endpoint, direction and bank of the last transaction
// Assumes: Completion strobe and record from logic on clock_i
// Notes:   All three fields load in one cycle
`timescale 1ns/10ps
module upts_xfer_status
  import upts_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // Completion
  input  wire logic       done_i,
  input  wire upts_xfer_t xfer_i,
  // Status
  output upts_xfer_t      last_o
);

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      last_o <= '0;                                        // [R11]
    else if (done_i)
      last_o <= xfer_i;                                    // [R7] [R12]
  end

endmodule : upts_xfer_status

// ### upts_monitor.sv
// Purpose: Port assertions for upts_top
// Assumes: One clock, async active-high reset
// Notes:   Bound after endmodule
`timescale 1ns/10ps
module upts_monitor
  import upts_pkg::*;
(
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rst_i,
  // APB
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Power and interrupt
  input wire logic        module_on_o,
  input wire logic        usb_clk_gate_o,
  input wire logic        xcvr_lowpwr_o,
  input wire logic        host_mode_enable_o,
  input wire logic        module_enable_o,
  input wire logic        otg_features_enable_o,
  input wire logic        irq_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire rd_ok  = pready_o && !pwrite_i;
  wire rd_pwr = rd_ok && paddr_i == UPTS_OFS_PWR;
  wire any_en = host_mode_enable_o | module_enable_o
              | otg_features_enable_o;

  a_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access phase not answered after one wait");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (pslverr_o |-> pready_o && psel_i)
    else $error("error without ready");
  a_gate_pair: assert property (usb_clk_gate_o == xcvr_lowpwr_o)
    else $error("clock gate and transceiver idle differ");
  a_pwr_outputs: assert property (rd_pwr |->
    module_on_o == prdata_o[0]
    && usb_clk_gate_o == (prdata_o[0] && prdata_o[1]))
    else $error("power outputs disagree with register");
  a_engine_on: assert property (any_en |-> module_on_o)
    else $error("engine enabled while module off");
  a_upper_zero: assert property (rd_ok |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_pwr_holes: assert property (rd_pwr |-> prdata_o[6:5] == 2'h0
    && prdata_o[3:2] == 2'h0) else $error("power holes not zero");
  a_stat_holes: assert property (rd_ok && paddr_i == UPTS_OFS_STAT
    |-> prdata_o[1:0] == 2'h0) else $error("status holes not zero");
  a_pend_guard: assert property (rd_pwr && prdata_o[7] |-> prdata_o[4])
    else $error("pending without guard");
  a_reset_quiet: assert property ($fell(rst_i) |->
    !pready_o && !module_on_o && !irq_o && !usb_clk_gate_o)
    else $error("outputs active after reset");

  c_gate: cover property ($rose(usb_clk_gate_o));
  c_irq:  cover property ($rose(irq_o));
  c_err:  cover property (pslverr_o);
  c_pend: cover property (rd_pwr && prdata_o[7]);
endmodule : upts_monitor

bind upts_top upts_monitor i_upts_monitor (
  .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .module_on_o(module_on_o), .usb_clk_gate_o(usb_clk_gate_o),
  .xcvr_lowpwr_o(xcvr_lowpwr_o), .host_mode_enable_o(host_mode_enable_o),
  .module_enable_o(module_enable_o), .irq_o(irq_o),
  .otg_features_enable_o(otg_features_enable_o));

// ### upts_usb_peer.sv
// Purpose: Engine and bus model beside upts_top
// Assumes: Driven by tasks from the bench
// Notes:   Record lines show the inverse of the last record after a send with keep clear ends, zero before the first
`timescale 1ns/10ps
module upts_usb_peer
  import upts_pkg::*;
#(
  parameter logic [15:0] PP_MASK = 16'h00ff
)
(
  // Clock
  input  wire logic clock_i,
  // Engine side
  output logic       xfer_done_o,
  output upts_xfer_t xfer_o,
  output logic       activity_o,
  output logic       bus_wake_o
);
  initial
  begin
    xfer_done_o = 1'b0;
    xfer_o      = '0;
    activity_o  = 1'b0;
    bus_wake_o  = 1'b0;
  end

  // Odd bank only exists on ping-pong endpoints
  task send(input logic [3:0] ep, input logic tx, od, input bit keep);
    xfer_done_o <= 1'b1;
    xfer_o <= '{endpoint: ep, transmit: tx, odd_bank: od & PP_MASK[ep]};
    @(posedge clock_i);
    if (!keep)
    begin
      xfer_done_o <= 1'b0;
      xfer_o      <= ~xfer_o;
    end
  endtask : send

  task busy(input logic lvl);
    activity_o <= lvl;
    @(posedge clock_i);
  endtask : busy

  task wake;
    bus_wake_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    bus_wake_o <= 1'b0;
  endtask : wake
endmodule : upts_usb_peer

// ### tb_top.sv
// Purpose: Self-checking bench for upts_top
// Assumes: One wait state per APB access
// Notes:   Seeded random transfer records
`timescale 1ns/10ps
module tb_top
  import upts_pkg::*;
;
  localparam logic [15:0] PP_MASK = 16'h00ff;
  logic        clock_i, rst_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, last;
  logic        pready_o, pslverr_o, xfer_done_i, activity_i, bus_wake_i;
  logic        module_on_o, gate_o, lowpwr_o, host_o, mod_o, otg_o, irq_o;
  upts_xfer_t  xfer_i;
  logic        tx, od;
  int          error_cnt, checked, seed, i;

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  upts_top i_upts_top (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .xfer_done_i(xfer_done_i), .xfer_i(xfer_i),
    .activity_i(activity_i), .bus_wake_i(bus_wake_i),
    .module_on_o(module_on_o), .usb_clk_gate_o(gate_o),
    .xcvr_lowpwr_o(lowpwr_o), .host_mode_enable_o(host_o),
    .module_enable_o(mod_o), .otg_features_enable_o(otg_o), .irq_o(irq_o));

  upts_usb_peer #(.PP_MASK(PP_MASK)) i_peer (.clock_i(clock_i),
    .xfer_done_o(xfer_done_i), .xfer_o(xfer_i), .activity_o(activity_i),
    .bus_wake_o(bus_wake_i));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function logic [31:0] stat_exp(logic [3:0] ep, logic t, logic o);
    return {24'h0, ep, t, o & PP_MASK[ep], 2'b00};
  endfunction : stat_exp

  task chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 16);
    // A lost answer counts as a mismatch rather than hanging the run
    if (n >= 16) error_cnt++;
    r = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, x);
    chk("slverr", {31'h0, e}, {31'h0, a > UPTS_OFS_ENG});
  endtask : rd

  // Arguments are copied at the call: callers let outputs settle first
  task bit1(input string nm, input logic v, input logic x);
    chk(nm, {31'h0, v}, {31'h0, x});
  endtask : bit1

  task summarize;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    summarize();
  end

  initial
  begin
    seed = 45;
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    for (i = 0; i < 6; i++) rd(8'(i * 4), 32'h0, "reset");
    wr(UPTS_OFS_PWR, 32'h1);
    wr(UPTS_OFS_PWR, 32'hffff_ffff);
    rd(UPTS_OFS_PWR, 32'h13, "pwr_all");
    bit1("gate", gate_o & lowpwr_o, 1'b1);
    i_peer.wake();
    repeat (6) @(posedge clock_i);
    rd(UPTS_OFS_PWR, 32'h11, "pwr_wake");
    bit1("gate_off", gate_o | lowpwr_o, 1'b0);
    rd(UPTS_OFS_IRQ_ST, 32'h2, "irq_wake");
    wr(UPTS_OFS_PWR, 32'h1);
    i_peer.busy(1'b1);
    rd(UPTS_OFS_PWR, 32'h1, "pend_noguard");
    wr(UPTS_OFS_PWR, 32'h11);
    rd(UPTS_OFS_PWR, 32'h91, "pend_on");
    i_peer.busy(1'b0);
    repeat (2) @(posedge clock_i);
    rd(UPTS_OFS_PWR, 32'h11, "pend_off");
    rd(UPTS_OFS_IRQ_ST, 32'h6, "irq_pend");
    wr(UPTS_OFS_IRQ_ST, 32'hffff_ffff);
    rd(UPTS_OFS_IRQ_ST, 32'h0, "irq_clr");
    wr(UPTS_OFS_ENG, 32'hffff_ffff);
    rd(UPTS_OFS_ENG, 32'h7, "eng");
    bit1("eng_out", host_o & mod_o & otg_o, 1'b1);
    wr(UPTS_OFS_IRQ_MSK, 32'h1);
    for (i = 0; i < 16; i++)
    begin
      tx = 1'($random(seed));
      od = 1'($random(seed));
      i_peer.send(4'(i), tx, od, 1'b0);
      last = stat_exp(4'(i), tx, od);
      rd(UPTS_OFS_STAT, last, "stat");
    end
    bit1("irq_on", irq_o, 1'b1);
    wr(UPTS_OFS_STAT, 32'hffff_ffff);
    rd(UPTS_OFS_STAT, last, "stat_ro");
    i_peer.send(4'h3, 1'b1, 1'b1, 1'b1);
    i_peer.send(4'hc, 1'b0, 1'b1, 1'b0);
    last = stat_exp(4'hc, 1'b0, 1'b1);
    rd(UPTS_OFS_STAT, last, "stat_b2b");
    wr(UPTS_OFS_IRQ_MSK, 32'h0);
    repeat (2) @(posedge clock_i);
    bit1("irq_mask", irq_o, 1'b0);
    wr(UPTS_OFS_IRQ_MSK, 32'h1);
    wr(UPTS_OFS_IRQ_ST, 32'h1);
    bit1("irq_w1c", irq_o, 1'b0);
    wr(UPTS_OFS_ENG, 32'h0);
    wr(UPTS_OFS_PWR, 32'h0);
    repeat (2) @(posedge clock_i);
    bit1("off", module_on_o, 1'b0);
    i_peer.send(4'h5, 1'b1, 1'b0, 1'b0);
    rd(UPTS_OFS_STAT, last, "stat_off");
    summarize();
  end
endmodule : tb_top
